// ---- hw/peripheral_soft_reset_regs.sv ----
/*
 * Peripheral soft reset register block: two control registers reached over
 * AHB-Lite, each assigned bit holding one peripheral in reset while set.
 * Assumes the capability masks arrive as stable levels from another block.
 */
`timescale 1ns/1ps

// Function
// - Writes to the first register change only bits enabled by mask two.
// - Writes to the second register change only bits enabled by mask four.
// - Bits 25 and 24 reset comparators 1 and 0; read/write, reset zero.
// - Bits 19 to 16 reset timers 3 to 0; read/write, reset zero.
// - Bits 14 and 12 reset two-wire units 1 and 0; reset zero.
// - Bits 5 and 4 reset synchronous serial units 1 and 0; reset zero.
// - Bits 2 to 0 reset asynchronous serial units 2 to 0; reset zero.
// - Second register bits 7 to 0 reset ports H to A; reset zero.
// - Unassigned bits are read-only zero; software preserves them.
module peripheral_soft_reset_regs (
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    input  wire logic                          clk_en,
    // AHB-Lite slave
    input  wire logic                          hsel,
    input  wire logic [soft_reset_pkg::ADDR_W-1:0] haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic                          hready,
    input  wire logic [31:0]                   hwdata,
    output logic      [31:0]                   hrdata,
    output logic                               hreadyout,
    output logic                               hresp,
    // Capability masks
    input  wire logic [31:0]                   capability_mask_two,
    input  wire logic [31:0]                   capability_mask_four,
    // Peripheral reset lines, active high
    output logic                               comparator_1_reset,
    output logic                               comparator_0_reset,
    output logic                               gp_timer_3_reset,
    output logic                               gp_timer_2_reset,
    output logic                               gp_timer_1_reset,
    output logic                               gp_timer_0_reset,
    output logic                               two_wire_1_reset,
    output logic                               two_wire_0_reset,
    output logic                               sync_serial_1_reset,
    output logic                               sync_serial_0_reset,
    output logic                               async_serial_2_reset,
    output logic                               async_serial_1_reset,
    output logic                               async_serial_0_reset,
    output logic                               port_h_reset,
    output logic                               port_g_reset,
    output logic                               port_f_reset,
    output logic                               port_e_reset,
    output logic                               port_d_reset,
    output logic                               port_c_reset,
    output logic                               port_b_reset,
    output logic                               port_a_reset
);
    import soft_reset_pkg::*;

    // ************************************************************
    // Register selection
    // ************************************************************
    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_A    = 2'b01,
        SEL_B    = 2'b10
    } reg_sel_t;

    function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] a);
        reg_sel_t s;
        s = SEL_NONE;
        case (a)
            PERIPHERAL_RESET_CTRL_A_OFS: s = SEL_A;
            PORT_RESET_CTRL_B_OFS:       s = SEL_B;
            default:                     s = SEL_NONE;
        endcase
        return s;
    endfunction : decode_addr

    // ************************************************************
    // Address phase capture
    // ************************************************************
    logic        wr_pend_r;
    reg_sel_t    wr_sel_r;
    logic        addr_take;
    reg_sel_t    addr_sel;
    logic [31:0] ctrl_a;
    logic [31:0] ctrl_b;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;

    // Zero-wait slave: every transfer completes in its first data cycle.
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;
    assign hrdata    = hrdata_r;
    assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign addr_sel  = decode_addr(haddr);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_r <= 1'b0;
            wr_sel_r  <= SEL_NONE;
        end else if (clk_en) begin
            wr_pend_r <= addr_take && hwrite;
            wr_sel_r  <= addr_sel;
        end
    end

    // ************************************************************
    // Control words
    // ************************************************************
    // Capability mask gates every write to the first word.
    reset_ctrl_word u_ctrl_a (
        .clock     (clock),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .wr_en     (wr_pend_r && (wr_sel_r == SEL_A)),
        .wr_data   (hwdata),
        .cap_mask  (capability_mask_two),
        .impl_mask (CTRL_A_IMPL_MASK),
        .value     (ctrl_a)
    );

    reset_ctrl_word u_ctrl_b (
        .clock     (clock),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .wr_en     (wr_pend_r && (wr_sel_r == SEL_B)),
        .wr_data   (hwdata),
        .cap_mask  (capability_mask_four),
        .impl_mask (CTRL_B_IMPL_MASK),
        .value     (ctrl_b)
    );

    // ************************************************************
    // Read data
    // ************************************************************
    // The read value is sampled at the address edge so hrdata is a flop.
    always_comb begin
        case (addr_sel)
            SEL_A:   hrdata_nxt = ctrl_a;
            SEL_B:   hrdata_nxt = ctrl_b;
            default: hrdata_nxt = READ_ZERO;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_r <= READ_ZERO;
        end else if (clk_en && addr_take && !hwrite) begin
            hrdata_r <= hrdata_nxt;
        end
    end

    // ************************************************************
    // Reset line fan-out
    // ************************************************************
    // Lines follow the words one cycle later, a set bit holds its unit.
    logic [31:0] hold_a;
    logic [31:0] hold_b;

    reset_fanout #(.WIDTH(32)) u_fan_a (
        .clock  (clock),
        .rst_n  (rst_n),
        .clk_en (clk_en),
        .ctrl   (ctrl_a),
        .hold   (hold_a)
    );

    reset_fanout #(.WIDTH(32)) u_fan_b (
        .clock  (clock),
        .rst_n  (rst_n),
        .clk_en (clk_en),
        .ctrl   (ctrl_b),
        .hold   (hold_b)
    );

    assign comparator_1_reset   = hold_a[COMPARATOR_1_BIT];
    assign comparator_0_reset   = hold_a[COMPARATOR_0_BIT];
    assign gp_timer_3_reset     = hold_a[GP_TIMER_LSB + 3];
    assign gp_timer_2_reset     = hold_a[GP_TIMER_LSB + 2];
    assign gp_timer_1_reset     = hold_a[GP_TIMER_LSB + 1];
    assign gp_timer_0_reset     = hold_a[GP_TIMER_LSB];
    assign two_wire_1_reset     = hold_a[TWO_WIRE_1_BIT];
    assign two_wire_0_reset     = hold_a[TWO_WIRE_0_BIT];
    assign sync_serial_1_reset  = hold_a[SYNC_SERIAL_1_BIT];
    assign sync_serial_0_reset  = hold_a[SYNC_SERIAL_0_BIT];
    assign async_serial_2_reset = hold_a[ASYNC_SERIAL_LSB + 2];
    assign async_serial_1_reset = hold_a[ASYNC_SERIAL_LSB + 1];
    assign async_serial_0_reset = hold_a[ASYNC_SERIAL_LSB];
    assign port_h_reset         = hold_b[PORT_LSB + 7];
    assign port_g_reset         = hold_b[PORT_LSB + 6];
    assign port_f_reset         = hold_b[PORT_LSB + 5];
    assign port_e_reset         = hold_b[PORT_LSB + 4];
    assign port_d_reset         = hold_b[PORT_LSB + 3];
    assign port_c_reset         = hold_b[PORT_LSB + 2];
    assign port_b_reset         = hold_b[PORT_LSB + 1];
    assign port_a_reset         = hold_b[PORT_LSB];

endmodule : peripheral_soft_reset_regs

// ---- hw/soft_reset_pkg.sv ----
/*
 * Constants for the peripheral soft reset register block: register offsets,
 * implemented-bit masks, field positions and the bus encodings.
 * Assumes a 32-bit AHB-Lite register bus and one system clock.
 */
package soft_reset_pkg;

    // ************************************************************
    // Bus encodings
    // ************************************************************
    localparam logic [1:0]  HTRANS_IDLE   = 2'h0;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_WORD    = 3'h2;
    localparam logic        HRESP_OKAY    = 1'h0;
    localparam int          ADDR_W        = 12;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [11:0] PERIPHERAL_RESET_CTRL_A_OFS = 12'h044;
    localparam logic [11:0] PORT_RESET_CTRL_B_OFS       = 12'h048;
    localparam logic [31:0] REG_RESET_VALUE             = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO                   = 32'h0000_0000;

    // ************************************************************
    // Implemented bits; every other position reads as zero
    // ************************************************************
    localparam logic [31:0] CTRL_A_IMPL_MASK = 32'h030F_5037;
    localparam logic [31:0] CTRL_B_IMPL_MASK = 32'h0000_00FF;

    // ************************************************************
    // Field positions in the first register
    // ************************************************************
    localparam int COMPARATOR_1_BIT = 25;
    localparam int COMPARATOR_0_BIT = 24;
    localparam int GP_TIMER_LSB     = 16;
    localparam int GP_TIMER_COUNT   = 4;
    localparam int TWO_WIRE_1_BIT   = 14;
    localparam int TWO_WIRE_0_BIT   = 12;
    localparam int SYNC_SERIAL_1_BIT = 5;
    localparam int SYNC_SERIAL_0_BIT = 4;
    localparam int ASYNC_SERIAL_LSB = 0;
    localparam int ASYNC_SERIAL_COUNT = 3;

    // ************************************************************
    // Field positions in the second register
    // ************************************************************
    localparam int PORT_LSB   = 0;
    localparam int PORT_COUNT = 8;

endpackage : soft_reset_pkg

// ---- hw/reset_ctrl_word.sv ----
/*
 * One masked soft reset control word. A write updates only bits that are
 * both implemented and enabled by the capability mask.
 * Assumes the write strobe is a one-cycle pulse on the system clock.
 */
`timescale 1ns/1ps

module reset_ctrl_word (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // Write side
    input  wire logic        wr_en,
    input  wire logic [31:0] wr_data,
    input  wire logic [31:0] cap_mask,
    input  wire logic [31:0] impl_mask,
    // State
    output logic      [31:0] value
);
    import soft_reset_pkg::*;

    logic [31:0] value_r;
    logic [31:0] value_nxt;
    logic [31:0] write_mask;

    assign write_mask = cap_mask & impl_mask;
    assign value_nxt  = (value_r & ~write_mask) | (wr_data & write_mask);
    assign value      = value_r & impl_mask;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            value_r <= REG_RESET_VALUE;
        end else if (clk_en && wr_en) begin
            value_r <= value_nxt;
        end
    end

endmodule : reset_ctrl_word

// ---- hw/reset_fanout.sv ----
/*
 * Expands a control word into individual active-high reset lines, one per
 * peripheral, registered so the lines are glitch free.
 * Assumes the peripherals take an active-high synchronous reset request.
 */
`timescale 1ns/1ps

module reset_fanout #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    // Control word
    input  wire logic [WIDTH-1:0] ctrl,
    // Reset lines
    output logic      [WIDTH-1:0] hold
);
    import soft_reset_pkg::*;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_line
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    hold[i] <= 1'b0;
                end else if (clk_en) begin
                    hold[i] <= ctrl[i];
                end
            end
        end
    endgenerate

endmodule : reset_fanout

// ---- bench/soft_reset_checker.sv ----
/* Port assertions for the soft reset register block.
   Assumes a bind to the top module, with hready fed from hreadyout. */
`timescale 1ns/1ps
module soft_reset_checker import soft_reset_pkg::*; (
    // Bus side
    input wire logic        clock, rst_n, clk_en, hsel, hwrite, hready,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic [31:0] hwdata, hrdata,
    input wire logic        hreadyout, hresp,
    // Masks and a sample of the reset lines
    input wire logic [31:0] capability_mask_two, capability_mask_four,
    input wire logic        comparator_1_reset, gp_timer_0_reset,
    input wire logic        port_a_reset, port_h_reset
);
    logic take, wr_a, wr_b, rd_un;
    assign take = hsel && hready && htrans == HTRANS_NONSEQ && clk_en;
    // Data phase flags; the write is stored at the end of that phase.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_a  <= 1'b0;
            wr_b  <= 1'b0;
            rd_un <= 1'b0;
        end else begin
            wr_a  <= take && hwrite && haddr == PERIPHERAL_RESET_CTRL_A_OFS;
            wr_b  <= take && hwrite && haddr == PORT_RESET_CTRL_B_OFS;
            rd_un <= take && !hwrite && haddr != PERIPHERAL_RESET_CTRL_A_OFS
                     && haddr != PORT_RESET_CTRL_B_OFS;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY)
        else $error("bus answer not ready and okay");
    a_reserved_zero: assert property ((hrdata & ~(CTRL_A_IMPL_MASK |
        CTRL_B_IMPL_MASK)) == READ_ZERO) else $error("reserved bit read 1");
    a_unmapped_zero: assert property (rd_un |-> hrdata == READ_ZERO)
        else $error("unmapped read not zero");
    a_cap_set_a: assert property (
        wr_a && clk_en && capability_mask_two[25]
        |=> ##1 comparator_1_reset == $past(hwdata[25], 2))
        else $error("comparator line missed write");
    a_cap_block_a: assert property (
        wr_a && !capability_mask_two[16]
        |=> ##1 $stable(gp_timer_0_reset))
        else $error("masked timer bit moved");
    a_cap_set_b: assert property (
        wr_b && clk_en && capability_mask_four[0]
        |=> ##1 port_a_reset == $past(hwdata[0], 2))
        else $error("port line missed write");
    a_cap_block_b: assert property (
        wr_b && !capability_mask_four[7]
        |=> ##1 $stable(port_h_reset))
        else $error("masked port bit moved");
    a_reset_clear: assert property (
        $rose(rst_n) |-> !comparator_1_reset
        && !port_a_reset && hrdata == READ_ZERO)
        else $error("not clear at reset");
    a_hold_steady: assert property (
        !wr_a |=> ##1 $stable(comparator_1_reset))
        else $error("reset line moved without write");
    c_write_a: cover property (wr_a && capability_mask_two[25]);
    c_write_b: cover property (wr_b && !capability_mask_four[7]);
    c_unmapped: cover property (rd_un);
endmodule : soft_reset_checker

// ---- bench/tb_peripheral_soft_reset_regs.sv ----
/* Self-checking bench for the soft reset register block.
   Assumes one AHB-Lite master, the bench, with zero-wait answers. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_peripheral_soft_reset_regs;
    import soft_reset_pkg::*;
    logic              clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
    logic              hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [ADDR_W-1:0] haddr = '0;
    logic [1:0]        htrans = HTRANS_IDLE;
    logic [2:0]        hsize = HSIZE_WORD;
    logic [31:0]       hwdata = '0, hrdata, cap2 = '1, cap4 = '1, q, v;
    wire  [12:0]       ln_a;
    wire  [7:0]        ln_b;
    logic [11:0]       ofs [2] = '{PERIPHERAL_RESET_CTRL_A_OFS,
                                   PORT_RESET_CTRL_B_OFS};
    logic [31:0]       msk [2] = '{CTRL_A_IMPL_MASK, CTRL_B_IMPL_MASK};
    int                err_total = 0, n_checks = 0, cycles = 0;
    always #2 clock = ~clock;
    peripheral_soft_reset_regs DUT (.clock(clock), .rst_n(rst_n),
        .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .capability_mask_two(cap2), .capability_mask_four(cap4),
        .comparator_1_reset(ln_a[12]), .comparator_0_reset(ln_a[11]),
        .gp_timer_3_reset(ln_a[10]), .gp_timer_2_reset(ln_a[9]),
        .gp_timer_1_reset(ln_a[8]), .gp_timer_0_reset(ln_a[7]),
        .two_wire_1_reset(ln_a[6]), .two_wire_0_reset(ln_a[5]),
        .sync_serial_1_reset(ln_a[4]), .sync_serial_0_reset(ln_a[3]),
        .async_serial_2_reset(ln_a[2]), .async_serial_1_reset(ln_a[1]),
        .async_serial_0_reset(ln_a[0]), .port_h_reset(ln_b[7]),
        .port_g_reset(ln_b[6]), .port_f_reset(ln_b[5]), .port_e_reset(ln_b[4]),
        .port_d_reset(ln_b[3]), .port_c_reset(ln_b[2]), .port_b_reset(ln_b[1]),
        .port_a_reset(ln_b[0]));
    function automatic logic [12:0] pack_a(input logic [31:0] x);
        return {x[25:24], x[19:16], x[14], x[12], x[5:4], x[2:0]};
    endfunction : pack_a
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done
    // One single transfer; called right after a rising edge.
    task automatic xfer(input logic [11:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        htrans <= HTRANS_IDLE;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        r = hrdata;
    endtask : xfer
    // Write, then read back and compare word and reset lines.
    task automatic wchk(input int r, input logic [31:0] d,
                        input logic [31:0] e);
        xfer(ofs[r], 1'b1, d, q);
        xfer(ofs[r], 1'b0, '0, q);
        `CHK("reg", e, q)
        if (r == 0)
            `CHK("lines_a", pack_a(e), ln_a)
        else
            `CHK("lines_b", e[7:0], ln_b)
    endtask : wchk
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        for (int r = 0; r < 2; r++) begin
            xfer(ofs[r], 1'b0, '0, q);
            `CHK("reset value", REG_RESET_VALUE, q)
        end
        `CHK("lines at reset", 21'h0, {ln_a, ln_b})
        $display("test reset values done");
        for (int i = 0; i < 32; i++)
            for (int r = 0; r < 2; r++)
                wchk(r, 32'h1 << i, (32'h1 << i) & msk[r]);
        $display("test walking bits done");
        for (int r = 0; r < 2; r++) begin
            wchk(r, '1, msk[r]);
            wchk(r, '0, '0);
            cap2 <= 32'h5A5A_5A5A;
            cap4 <= 32'h0000_00A5;
            v = r ? 32'h0000_00A5 : 32'h5A5A_5A5A;
            wchk(r, '1, msk[r] & v);
            cap2 <= 32'hA5A5_A5A5;
            cap4 <= 32'hFFFF_FF5A;
            wchk(r, '0, msk[r] & v);
            cap2 <= '1;
            cap4 <= '1;
        end
        $display("test capability masks done");
        xfer(12'h04C, 1'b1, '1, q);
        xfer(12'h040, 1'b1, '1, q);
        xfer(12'h04C, 1'b0, '0, q);
        `CHK("unmapped read", READ_ZERO, q)
        xfer(ofs[1], 1'b0, '0, q);
        `CHK("reg b kept", 32'h0000_00A5, q)
        $display("test unmapped done");
        // A write made while the enable is low must leave no trace.
        clk_en <= 1'b0;
        xfer(ofs[1], 1'b1, '0, q);
        clk_en <= 1'b1;
        xfer(ofs[1], 1'b0, '0, q);
        `CHK("reg b frozen", 32'h0000_00A5, q)
        `CHK("lines b frozen", 8'hA5, ln_b)
        $display("test clock enable done");
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        xfer(ofs[0], 1'b0, '0, q);
        `CHK("reg a after reset", REG_RESET_VALUE, q)
        `CHK("lines after reset", 21'h0, {ln_a, ln_b})
        $display("test mid reset done");
        test_done();
    end
endmodule : tb_peripheral_soft_reset_regs
bind peripheral_soft_reset_regs soft_reset_checker chk (.clock, .rst_n,
    .clk_en, .hsel, .hwrite, .hready, .haddr, .htrans, .hwdata, .hrdata,
    .hreadyout, .hresp, .capability_mask_two, .capability_mask_four,
    .comparator_1_reset, .gp_timer_0_reset, .port_a_reset, .port_h_reset);
